/* File: rtl/htc_pkg.sv */
// Purpose: Shared constants for the upper hybrid echo tap coefficient store.
// Assumes: Registers are addressed by their 8-bit register number.
// Notes:   Coefficients and samples are signed two's complement values.
package htc_pkg;

  // Register numbers of the three upper tap coefficients.
  localparam logic [7:0] HTC_TAP6_ADDR  = 8'h32;
  localparam logic [7:0] HTC_TAP7_ADDR  = 8'h33;
  localparam logic [7:0] HTC_TAP8_ADDR  = 8'h34;

  // Reserved register range that follows the taps.
  localparam logic [7:0] HTC_RSVD_LO    = 8'h35;
  localparam logic [7:0] HTC_RSVD_HI    = 8'h3a;

  // Widths of the datapath.
  localparam int         HTC_COEFF_W    = 8;
  localparam int         HTC_SAMPLE_W   = 16;
  localparam int         HTC_PROD_W     = HTC_COEFF_W + HTC_SAMPLE_W;
  localparam int         HTC_SUM_W      = HTC_PROD_W + 2;

  // Tap structure: three taps held here, the first being tap six.
  localparam int         HTC_NUM_TAPS   = 3;
  localparam int         HTC_FIRST_TAP  = 6;
  localparam int         HTC_HIST_DEPTH = 8;

  // Value of every coefficient after reset.
  localparam logic [7:0] HTC_COEFF_RST  = 8'h00;

  // Cycles from the loading of history and applied taps to the partial sum.
  localparam int         HTC_SUM_LAT    = 2;

endpackage

/* File: rtl/htc_tap_if.sv */
// Purpose: Carries one tap's sample, coefficient and product between modules.
// Assumes: The top drives sample and coefficient, the stage returns the product.
// Notes:   One instance per tap.
`timescale 1ns/1ps

interface htc_tap_if;
  import htc_pkg::*;

  logic signed [HTC_SAMPLE_W-1:0] sample;
  logic signed [HTC_COEFF_W-1:0]  coeff;
  logic signed [HTC_PROD_W-1:0]   product;

  // Top side feeds the stage.
  modport top   (output sample, output coeff, input product);
  // Stage side computes the tap product.
  modport stage (input sample, input coeff, output product);
endinterface

/* File: rtl/htc_tap_stage.sv */
// Purpose: One filter stage: registered product of sample and coefficient.
// Assumes: Synchronous active-low reset on the shared clock.
// Notes:   A zero coefficient yields a zero product on the next edge.
`timescale 1ns/1ps

module htc_tap_stage
  import htc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  htc_tap_if.stage  tap
);

  logic signed [HTC_PROD_W-1:0] next_product;

  // Multiply the delayed sample by the applied coefficient.
  always_comb
  begin
    next_product = tap.sample * tap.coeff;
  end

  // Register the product so the summer sees a clean value.
  always_ff @(posedge clk)
  begin
    if (!rstn)
      tap.product <= '0;
    else
      tap.product <= next_product;
  end

  // A cleared coefficient must leave no trace in the product.
  AST_ZERO_TAP: assert property (@(posedge clk) disable iff (!rstn)
    tap.coeff == '0 |=> tap.product == '0)
    else $error("Zero coefficient gave a nonzero product.");

endmodule

/* File: rtl/htc_core.sv */
// Purpose: Coefficient store and partial sum for taps six to eight of the hybrid.
// Assumes: Register writes and reads arrive as one-cycle strobes on the clock.
// Notes:   Written values are applied only at the next sample strobe.
`timescale 1ns/1ps

// Functional notes
// - Register 50 holds tap six coefficient.
// - Register 51 holds tap seven coefficient.
// - Register 52 holds tap eight coefficient.
// - Zero coefficient makes its stage contribute nothing.
// - Taps seven and eight reset to zero.
module htc_core
  import htc_pkg::*;
(
  input  wire logic                                clk,
  input  wire logic                                rstn,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  input  wire logic [7:0]                          reg_addr,
  input  wire logic [HTC_COEFF_W-1:0]              reg_wdata,
  output logic      [HTC_COEFF_W-1:0]              reg_rdata,
  input  wire logic                                sample_strobe,
  input  wire logic signed [HTC_SAMPLE_W-1:0]      sample_in,
  output logic      [HTC_COEFF_W-1:0]              tap_six_coefficient,
  output logic      [HTC_COEFF_W-1:0]              tap_seven_coefficient,
  output logic      [HTC_COEFF_W-1:0]              tap_eight_coefficient,
  output logic signed [htc_pkg::HTC_SUM_W-1:0]     hybrid_sum,
  output logic                                     sum_valid
);
  import htc_pkg::*;

  // Register-number decode: hit flag and tap index.
  function automatic logic [2:0] tap_decode(input logic [7:0] addr);
    logic [2:0] res;
    res = 3'h0;
    case (addr)
      HTC_TAP6_ADDR: res = 3'h4;
      HTC_TAP7_ADDR: res = 3'h5;
      HTC_TAP8_ADDR: res = 3'h6;
      default:       res = 3'h0;
    endcase
    return res;
  endfunction

  logic [HTC_COEFF_W-1:0]         coeff_reg  [HTC_NUM_TAPS];
  logic [HTC_COEFF_W-1:0]         next_coeff [HTC_NUM_TAPS];
  logic [HTC_COEFF_W-1:0]         act_coeff  [HTC_NUM_TAPS];
  logic [HTC_COEFF_W-1:0]         next_act   [HTC_NUM_TAPS];
  logic signed [HTC_SAMPLE_W-1:0] hist       [HTC_HIST_DEPTH];
  logic signed [HTC_SAMPLE_W-1:0] next_hist  [HTC_HIST_DEPTH];
  logic [HTC_COEFF_W-1:0]         next_rdata;
  logic signed [HTC_SUM_W-1:0]    next_sum;
  logic                           hist_valid;
  logic                           prod_valid;
  logic [2:0]                     wr_dec;
  logic [2:0]                     rd_dec;

  htc_tap_if tap_bus [HTC_NUM_TAPS] ();

  assign wr_dec = tap_decode(reg_addr);
  assign rd_dec = wr_dec;

  // Host-side coefficient registers; writes to the reserved range fall through.
  always_comb
  begin
    for (int i = 0; i < HTC_NUM_TAPS; i++)
    begin
      next_coeff[i] = coeff_reg[i];
      if (reg_wr && wr_dec[2] && (wr_dec[1:0] == 2'(i)))
        next_coeff[i] = reg_wdata;
    end
  end

  // Applied coefficients load whole on the sample strobe only.
  always_comb
  begin
    for (int i = 0; i < HTC_NUM_TAPS; i++)
    begin
      next_act[i] = act_coeff[i];
      if (sample_strobe)
        next_act[i] = next_coeff[i];
    end
  end

  // Sample history shifts once per strobe.
  always_comb
  begin
    for (int i = 0; i < HTC_HIST_DEPTH; i++)
      next_hist[i] = hist[i];
    if (sample_strobe)
    begin
      next_hist[0] = sample_in;
      for (int i = 1; i < HTC_HIST_DEPTH; i++)
        next_hist[i] = hist[i-1];
    end
  end

  // Read data: mapped coefficient, zero for reserved or unmapped numbers.
  always_comb
  begin
    next_rdata = reg_rdata;
    if (reg_rd)
      next_rdata = rd_dec[2] ? coeff_reg[rd_dec[1:0]] : '0;
  end

  // Partial sum of the three tap products.
  always_comb
  begin
    next_sum = HTC_SUM_W'(tap_bus[0].product)
             + HTC_SUM_W'(tap_bus[1].product)
             + HTC_SUM_W'(tap_bus[2].product);
  end

  // Register every group of state.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < HTC_NUM_TAPS; i++)
      begin
        coeff_reg[i] <= HTC_COEFF_RST;
        act_coeff[i] <= HTC_COEFF_RST;
      end
      for (int i = 0; i < HTC_HIST_DEPTH; i++)
        hist[i] <= '0;
      reg_rdata  <= '0;
      hist_valid <= 1'b0;
      prod_valid <= 1'b0;
      sum_valid  <= 1'b0;
      hybrid_sum <= '0;
    end
    else
    begin
      coeff_reg  <= next_coeff;
      act_coeff  <= next_act;
      hist       <= next_hist;
      reg_rdata  <= next_rdata;
      hist_valid <= sample_strobe; // History and applied taps are loaded.
      prod_valid <= hist_valid;    // Tap products are registered.
      sum_valid  <= prod_valid;    // Marks the cycle in which the new sum stands.
      hybrid_sum <= next_sum;
    end
  end

  assign tap_six_coefficient   = act_coeff[0];
  assign tap_seven_coefficient = act_coeff[1];
  assign tap_eight_coefficient = act_coeff[2];

  // One stage per tap; tap k uses the sample delayed by k-1 strobes.
  generate
    for (genvar g = 0; g < HTC_NUM_TAPS; g++)
    begin : g_tap
      assign tap_bus[g].sample = hist[HTC_FIRST_TAP - 1 + g];
      assign tap_bus[g].coeff  = act_coeff[g];
      htc_tap_stage u_stage (
        .clk  (clk),
        .rstn (rstn),
        .tap  (tap_bus[g])
      );
    end
  endgenerate

  // Checks on the register file and the apply timing.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_WR_TAP6: assert property (reg_wr && reg_addr == HTC_TAP6_ADDR |=>
    coeff_reg[0] == $past(reg_wdata))
    else $error("Tap six write not stored.");
  AST_WR_TAP7: assert property (reg_wr && reg_addr == HTC_TAP7_ADDR |=>
    coeff_reg[1] == $past(reg_wdata))
    else $error("Tap seven write not stored.");
  AST_WR_TAP8: assert property (reg_wr && reg_addr == HTC_TAP8_ADDR |=>
    coeff_reg[2] == $past(reg_wdata) ##1 (!reg_wr || 1'b1))
    else $error("Tap eight write not stored.");
  AST_RST_ZERO: assert property (disable iff (1'b0) !rstn |=>
    act_coeff[1] == '0 && act_coeff[2] == '0 && coeff_reg[2] == '0)
    else $error("Upper taps not cleared by reset.");
  AST_HOLD: assert property (!sample_strobe |=> $stable(tap_six_coefficient)
    && $stable(tap_eight_coefficient))
    else $error("Applied coefficient changed between samples.");
  AST_APPLY: assert property (sample_strobe && !reg_wr |=>
    tap_seven_coefficient == $past(coeff_reg[1]))
    else $error("Coefficient not applied at sample strobe.");
  AST_RSVD_RD: assert property (reg_rd && reg_addr >= HTC_RSVD_LO
    && reg_addr <= HTC_RSVD_HI |=> reg_rdata == '0)
    else $error("Reserved register read not zero.");
  // The valid pulse must coincide with the first cycle of the new sum.
  AST_SUM_LAT: assert property (sample_strobe |-> ##3 sum_valid)
    else $error("Partial sum valid not aligned with the new sum.");
  AST_ZERO_SUM: assert property (act_coeff[0] == '0 && act_coeff[1] == '0
    && act_coeff[2] == '0 && !sample_strobe ##1 !sample_strobe |=> hybrid_sum == '0)
    else $error("Cleared taps still contribute to the sum.");

  // A write in the same cycle as a strobe is applied by that strobe.
  AST_SAME_APPLY: assert property (sample_strobe && reg_wr
    && reg_addr == HTC_TAP6_ADDR |=> tap_six_coefficient == $past(reg_wdata))
    else $error("Same-cycle write not applied at the strobe.");

  // Read data stand until the next read strobe.
  AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("Read data changed without a read strobe.");

  // Reads of the taps return the stored, not the applied, coefficient.
  AST_RD_TAP6: assert property (reg_rd && reg_addr == HTC_TAP6_ADDR |=>
    reg_rdata == $past(coeff_reg[0]))
    else $error("Tap six read does not return the stored value.");
  AST_RD_TAP7: assert property (reg_rd && reg_addr == HTC_TAP7_ADDR |=>
    reg_rdata == $past(coeff_reg[1]))
    else $error("Tap seven read does not return the stored value.");
  AST_RD_TAP8: assert property (reg_rd && reg_addr == HTC_TAP8_ADDR |=>
    reg_rdata == $past(coeff_reg[2]))
    else $error("Tap eight read does not return the stored value.");

  // Main scenarios worth seeing in coverage.
  COV_WRITE_APPLY: cover property (reg_wr && reg_addr == HTC_TAP6_ADDR ##1 sample_strobe);
  COV_READ_TAP8:   cover property (reg_rd && reg_addr == HTC_TAP8_ADDR);
  COV_SUM_NONZERO: cover property (sum_valid && hybrid_sum != '0);
  COV_SAME_APPLY:  cover property (sample_strobe && reg_wr);
  COV_RSVD_READ:   cover property (reg_rd && reg_addr == HTC_RSVD_LO);

endmodule

/* File: verif/htc_core_tb.sv */
// Purpose: Self-checking bench for the upper hybrid tap coefficient store.
// Assumes: Inputs change 1 ns after the rising edge; the sum follows a strobe by three edges.
// Notes:   A small model keeps stored coefficients and sample history for expectations.
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end

module testbench;
  import htc_pkg::*;
  logic                           clk = 1'b0;
  logic                           rstn = 1'b0;
  logic                           reg_wr = 1'b0;
  logic                           reg_rd = 1'b0;
  logic [7:0]                     reg_addr = 8'h00;
  logic [HTC_COEFF_W-1:0]         reg_wdata = 8'h00;
  logic [HTC_COEFF_W-1:0]         reg_rdata;
  logic                           sample_strobe = 1'b0;
  logic signed [HTC_SAMPLE_W-1:0] sample_in = 16'h0000;
  logic [HTC_COEFF_W-1:0]         tap_six_coefficient;
  logic [HTC_COEFF_W-1:0]         tap_seven_coefficient;
  logic [HTC_COEFF_W-1:0]         tap_eight_coefficient;
  logic signed [HTC_SUM_W-1:0]    hybrid_sum;
  logic                           sum_valid;
  logic [7:0]                     pend [3];
  logic signed [HTC_SAMPLE_W-1:0] hist [8];
  int                             err_count = 0;
  int                             cmp_count = 0;

  htc_core i_htc_core (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_strobe(sample_strobe), .sample_in(sample_in),
    .tap_six_coefficient(tap_six_coefficient), .tap_seven_coefficient(tap_seven_coefficient),
    .tap_eight_coefficient(tap_eight_coefficient), .hybrid_sum(hybrid_sum),
    .sum_valid(sum_valid));

  // Clock of 100 MHz.
  always #5 clk = ~clk;

  // Moves to 1 ns after the next rising edge.
  task automatic step;
    @(posedge clk);
    #1;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Holds reset for six cycles and clears the model.
  task automatic do_reset;
    rstn = 1'b0;
    repeat (6) step;
    rstn = 1'b1;
    step;
    pend = '{8'h00, 8'h00, 8'h00};
    foreach (hist[i]) hist[i] = 16'h0000;
  endtask

  // One-cycle register write and an idle cycle; the model keeps mapped taps only.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    step;
    reg_wr = 1'b0;
    if (a >= HTC_TAP6_ADDR && a <= HTC_TAP8_ADDR) pend[a - HTC_TAP6_ADDR] = d;
    step;
  endtask

  // One-cycle register read, compared on the following cycle.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    reg_rd = 1'b1;
    reg_addr = a;
    step;
    `CHK(nm, exp, reg_rdata)
    reg_rd = 1'b0;
    step;
  endtask

  // Pushes one sample and checks applied coefficients, valid timing and the sum.
  task automatic strobe(input logic signed [15:0] s);
    logic signed [HTC_SUM_W-1:0] exp_sum;
    for (int i = 7; i > 0; i--) hist[i] = hist[i-1];
    hist[0] = s;
    exp_sum = '0;
    for (int k = 0; k < 3; k++) exp_sum += $signed(pend[k]) * hist[5+k];
    sample_strobe = 1'b1;
    sample_in = s;
    step;
    sample_strobe = 1'b0;
    `CHK("tap six", pend[0], tap_six_coefficient)
    `CHK("tap seven", pend[1], tap_seven_coefficient)
    `CHK("tap eight", pend[2], tap_eight_coefficient)
    `CHK("early valid", 1'b0, sum_valid)
    step;
    `CHK("mid valid", 1'b0, sum_valid)
    step;
    `CHK("valid", 1'b1, sum_valid)
    `CHK("sum", exp_sum, hybrid_sum)
  endtask

  // Reset values of taps seven and eight and of the read port.
  task automatic t_reset;
    `CHK("rst tap seven", HTC_COEFF_RST, tap_seven_coefficient)
    `CHK("rst tap eight", HTC_COEFF_RST, tap_eight_coefficient)
    rd(HTC_TAP7_ADDR, 8'h00, "rst rd seven");
    rd(HTC_TAP8_ADDR, 8'h00, "rst rd eight");
  endtask

  // Each tap is written then read back at once; applied values wait for a strobe.
  task automatic t_regs;
    wr(HTC_TAP6_ADDR, 8'ha5);
    rd(HTC_TAP6_ADDR, 8'ha5, "tap six rw");
    wr(HTC_TAP7_ADDR, 8'h5a);
    rd(HTC_TAP7_ADDR, 8'h5a, "tap seven rw");
    wr(HTC_TAP8_ADDR, 8'hff);
    rd(HTC_TAP8_ADDR, 8'hff, "tap eight rw");
    `CHK("held six", 8'h00, tap_six_coefficient)
    `CHK("held eight", 8'h00, tap_eight_coefficient)
  endtask

  // Reserved reads give zero; unmapped writes leave the taps alone.
  task automatic t_rsvd;
    rd(HTC_RSVD_LO, 8'h00, "rsvd lo");
    rd(HTC_RSVD_HI, 8'h00, "rsvd hi");
    wr(8'h31, 8'h11);
    wr(8'h3b, 8'h22);
    rd(HTC_TAP6_ADDR, 8'ha5, "six kept");
    rd(HTC_TAP8_ADDR, 8'hff, "eight kept");
  endtask

  // Filter sums with signed coefficients, then with one stage zeroed.
  task automatic t_sum;
    for (int n = 1; n <= 9; n++) strobe(16'(n * 1237 - 6000));
    wr(HTC_TAP7_ADDR, 8'h00);
    wr(HTC_TAP8_ADDR, 8'h81);
    strobe(16'h7fff);
    strobe(16'h8000);
    // A write in the same cycle as a strobe is applied by that strobe.
    reg_wr = 1'b1;
    reg_addr = HTC_TAP6_ADDR;
    reg_wdata = 8'h3c;
    sample_strobe = 1'b1;
    pend[0] = 8'h3c;
    step;
    reg_wr = 1'b0;
    sample_strobe = 1'b0;
    `CHK("same cycle six", 8'h3c, tap_six_coefficient)
    step;
  endtask

  // Bounds the whole run.
  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    stop_test;
  end

  // Main sequence, with a second reset in mid-run.
  initial
  begin
    do_reset;
    t_reset;
    t_regs;
    t_rsvd;
    t_sum;
    do_reset;
    t_reset;
    stop_test;
  end
endmodule
